// ==== bench/fpt_host_model.sv ====
// host model: drives register strobes and keeps the fan setup order
`timescale 1ns/1ps
module fpt_host_model (
  input wire logic clk_i,
  output fpt_pkg::fpt_req_s req_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial req_o = '0;
  // one write pulse, any order once set up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_o.wr <= 1'b0;
  endtask : wr
  // read pulse, then a bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_o.rd <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (rvalid_i !== 1'b1 && n < 4);
    d = rdata_i;
    if (rvalid_i !== 1'b1) begin
      tb_fan_pwm_tach_control.n_mismatch++;
      tb_fan_pwm_tach_control.end_sim();
    end
  endtask : rd
  // ****************************************
  // setup sequence
  // ****************************************
  task automatic init(input logic [7:0] cfg, input logic [7:0] freq, input logic [7:0] pwm, input logic use_lut,
                      input logic [7:0] lut [16]);
    wr(fpt_pkg::ADDR_FAN_CONFIG, cfg | 8'h20);
    wr(fpt_pkg::ADDR_SPINUP, 8'h00);
    wr(fpt_pkg::ADDR_PWM_FREQ, freq);
    if (use_lut) begin // table or direct value, never both
      for (int i = 0; i < 16; i++) wr(fpt_pkg::ADDR_LUT_BASE + 8'(i), lut[i]);
      wr(fpt_pkg::ADDR_FAN_CONFIG, cfg & 8'hdf); // hand over to table
    end else begin
      wr(fpt_pkg::ADDR_PWM_VALUE, pwm);
    end
  endtask : init
  // speed of a two pulse fan, factor 1
  function automatic int rpm(input int cnt);
    return (cnt == 0) ? 0 : 5400000 / cnt;
  endfunction : rpm
endmodule : fpt_host_model

// ==== bench/tb_fan_pwm_tach_control.sv ====
// self-checking bench for the fan pwm and tach block
`timescale 1ns/1ps
module tb_fan_pwm_tach_control;
  localparam int FAST = 4;
  localparam int SLOW = 20;
  localparam int TDIV = 6;
  logic clk;
  logic rst_n;
  fpt_pkg::fpt_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic [15:0] temp_in;
  logic temp_vld;
  logic [15:0] temp_out;
  logic tach;
  logic pwm_oe;
  logic [7:0] d;
  int n_mismatch = 0;
  int tests_run = 0;
  int cnt;
  // table: thresholds 20, 30, 40 then 127; pwm 1, 3, 5 then 7
  logic [7:0] lut [16] = '{8'h14, 8'h01, 8'h1e, 8'h03, 8'h28, 8'h05, 8'h7f, 8'h07,
                           8'h7f, 8'h07, 8'h7f, 8'h07, 8'h7f, 8'h07, 8'h7f, 8'h07};
  // ordinary rows: address, write data, read-back value
  logic [23:0] rows [8] = '{24'h4b_ff_3f, 24'h4c_ff_3f, 24'h4d_ff_1f, 24'h11_a5_a5, 24'h12_ff_e0,
                            24'h30_5a_00, 24'h46_77_00, 24'h47_77_00};
  // table cases: temperature input, pwm on cycles in 64
  logic [31:0] lut_cases [4] = '{32'h2300_0018, 32'h0a00_0000, 32'hf600_0000, 32'h7f00_0038};

  fpt_fan_ctrl #(.SLOW_DIV(SLOW), .FAST_DIV(FAST), .TACH_DIV(TDIV)) fpt_fan_ctrl_inst (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_WR_I(req.wr), .REG_RD_I(req.rd), .REG_ADDR_I(req.addr),
    .REG_WDATA_I(req.wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .REMOTE_TEMP_I(temp_in),
    .REMOTE_TEMP_VALID_I(temp_vld), .REMOTE_TEMP_O(temp_out), .TACH_I(tach), .PWM_OE_O(pwm_oe));
  fpt_host_model fpt_host_model_inst (.clk_i(clk), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  // ****************************************
  // clock and helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask : reset
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    fpt_host_model_inst.rd(a, d);
    chk(name, {8'h00, exp}, {8'h00, d});
  endtask : rdchk
  // settle one window, then count pin-low cycles over the next
  task automatic duty(input int win, input int exp);
    repeat (win) @(posedge clk);
    cnt = 0;
    repeat (win) begin
      @(posedge clk);
      #1;
      if (pwm_oe === 1'b1) cnt++;
    end
    chk("pwm on cycles", 16'(exp), 16'(cnt));
  endtask : duty
  task automatic tempchk(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] raw, input logic [15:0] exp);
    fpt_host_model_inst.wr(fpt_pkg::ADDR_OFFSET_HIGH, hi);
    fpt_host_model_inst.wr(fpt_pkg::ADDR_OFFSET_LOW, lo);
    @(posedge clk);
    temp_in <= raw;
    temp_vld <= 1'b1;
    @(posedge clk);
    temp_vld <= 1'b0;
    @(posedge clk);
    #1;
    chk("corrected temp", exp, temp_out);
  endtask : tempchk

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    temp_in = 16'h0000;
    temp_vld = 1'b0;
    tach = 1'b0;
    reset();
    #1;
    chk("rvalid after reset", 16'h0000, {15'h0000, rvalid});
    chk("temp after reset", 16'h0000, temp_out);
    chk("pwm after reset", 16'h0000, {15'h0000, pwm_oe});
    rdchk(fpt_pkg::ADDR_FAN_CONFIG, fpt_pkg::CFG_RST, "fan config reset");
    fpt_host_model_inst.init(8'h00, 8'h04, 8'h02, 1'b0, lut);
    // register rows through one loop
    foreach (rows[i]) begin
      fpt_host_model_inst.wr(rows[i][23:16], rows[i][15:8]);
      rdchk(rows[i][23:16], rows[i][7:0], "register readback");
    end
    // direct pwm: 2 of 8 ticks, fast, inverted, slow
    fpt_host_model_inst.wr(fpt_pkg::ADDR_PWM_FREQ, 8'h04);
    fpt_host_model_inst.wr(fpt_pkg::ADDR_PWM_VALUE, 8'h02);
    duty(64, 16);
    fpt_host_model_inst.wr(fpt_pkg::ADDR_FAN_CONFIG, 8'h30);
    duty(64, 48);
    fpt_host_model_inst.wr(fpt_pkg::ADDR_FAN_CONFIG, 8'h28);
    duty(320, 80);
    // offset added as signed value, fraction bits dropped
    tempchk(8'h01, 8'h00, 16'h191f, 16'h1a00);
    tempchk(8'hff, 8'h00, 16'h1900, 16'h1800);
    tempchk(8'h00, 8'h20, 16'h1900, 16'h1920);
    // table control after a fresh setup
    reset();
    fpt_host_model_inst.init(8'h00, 8'h04, 8'h00, 1'b1, lut);
    foreach (lut_cases[i]) begin
      tempchk(8'h00, 8'h00, lut_cases[i][31:16], lut_cases[i][31:16]);
      duty(64, int'(lut_cases[i][15:0]));
    end
    // tach: rising edge every 900 clocks, 1800 per revolution
    fpt_host_model_inst.wr(fpt_pkg::ADDR_FAN_CONFIG, 8'h21);
    repeat (8) begin
      @(posedge clk);
      tach <= 1'b1;
      repeat (450) @(posedge clk);
      tach <= 1'b0;
      repeat (449) @(posedge clk);
    end
    rdchk(fpt_pkg::ADDR_TACH_LOW, 8'h2c, "tach count low");
    cnt = int'(d);
    rdchk(fpt_pkg::ADDR_TACH_HIGH, 8'h01, "tach count high");
    cnt = cnt + 256 * int'(d);
    chk("fan rpm", 16'd18000, 16'(fpt_host_model_inst.rpm(cnt)));
    end_sim();
  end
endmodule : tb_fan_pwm_tach_control

// ==== design/fpt_fan_ctrl.sv ====
// fan pwm generator, tach period counter, offset correction and register file
`timescale 1ns/1ps
module fpt_fan_ctrl #(
  parameter int SLOW_DIV = fpt_pkg::PWM_SLOW_DIV,
  parameter int FAST_DIV = fpt_pkg::PWM_FAST_DIV,
  parameter int TACH_DIV = fpt_pkg::TACH_DIV
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic [15:0] REMOTE_TEMP_I,
  input wire logic REMOTE_TEMP_VALID_I,
  output logic [15:0] REMOTE_TEMP_O,
  input wire logic TACH_I,
  output logic PWM_OE_O
);
  // ****************************************
  // parameter checks
  // ****************************************
  if (SLOW_DIV < 2 || SLOW_DIV >= (1 << fpt_pkg::DIV_W) || FAST_DIV < 2 || FAST_DIV >= (1 << fpt_pkg::DIV_W)
      || TACH_DIV < 2 || TACH_DIV >= (1 << fpt_pkg::DIV_W)) begin : g_bad_div
    $error("fpt_fan_ctrl: divider out of range");
  end

  localparam logic [fpt_pkg::DIV_W-1:0] SLOW_LAST = fpt_pkg::DIV_W'(SLOW_DIV - 1);
  localparam logic [fpt_pkg::DIV_W-1:0] FAST_LAST = fpt_pkg::DIV_W'(FAST_DIV - 1);
  localparam logic [fpt_pkg::DIV_W-1:0] TACH_LAST = fpt_pkg::DIV_W'(TACH_DIV - 1);

  function automatic logic is_lut(input logic [7:0] a);
    is_lut = (a >= fpt_pkg::ADDR_LUT_BASE) && (a <= fpt_pkg::ADDR_LUT_LAST);
  endfunction : is_lut

  // ****************************************
  // register file
  // ****************************************
  fpt_pkg::fpt_req_s req;
  logic [7:0] cfg_reg, spinup_reg, pwm_value_reg, freq_reg, off_hi_reg, off_lo_reg;
  logic [7:0] tach_hi_snap_reg;
  logic [15:0] tach_count_reg;
  logic wr_lut;

  // request bundle and write decode
  assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I, wdata: REG_WDATA_I};
  assign wr_lut = req.wr && is_lut(req.addr);

  // host writable registers
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      cfg_reg <= fpt_pkg::CFG_RST;
      spinup_reg <= fpt_pkg::REG_RST;
      pwm_value_reg <= fpt_pkg::REG_RST;
      freq_reg <= fpt_pkg::REG_RST;
      off_hi_reg <= fpt_pkg::REG_RST;
      off_lo_reg <= fpt_pkg::REG_RST;
    end else if (req.wr) begin
      case (req.addr)
        fpt_pkg::ADDR_FAN_CONFIG: cfg_reg <= req.wdata;
        fpt_pkg::ADDR_SPINUP: spinup_reg <= {2'h0, req.wdata[fpt_pkg::SPINUP_W-1:0]};
        fpt_pkg::ADDR_PWM_VALUE: pwm_value_reg <= {2'h0, req.wdata[fpt_pkg::PWM_VAL_W-1:0]};
        fpt_pkg::ADDR_PWM_FREQ: freq_reg <= {3'h0, req.wdata[fpt_pkg::FREQ_W-1:0]};
        fpt_pkg::ADDR_OFFSET_HIGH: off_hi_reg <= req.wdata;
        fpt_pkg::ADDR_OFFSET_LOW: off_lo_reg <= {req.wdata[7:fpt_pkg::OFF_FRAC_LSB], 5'h00};
        default: ;
      endcase
    end
  end

  // ****************************************
  // lookup table memory and scanner
  // ****************************************
  logic [3:0] scan_addr_reg, scan_addr_d_reg;
  logic [7:0] host_lut_data, scan_data, best_reg, table_pwm_reg, best_next;
  logic match_reg;
  logic signed [7:0] temp_int;

  fpt_lut_mem #(.WORDS(fpt_pkg::LUT_WORDS), .WIDTH(8), .AW(4)) u_lut (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .wr_i(wr_lut),
    .waddr_i(req.addr[3:0]),
    .wdata_i(req.wdata),
    .raddr_a_i(req.addr[3:0]),
    .rdata_a_o(host_lut_data),
    .raddr_b_i(scan_addr_reg),
    .rdata_b_o(scan_data)
  );

  // even words are thresholds, odd words the pwm paired with them
  assign temp_int = signed'(REMOTE_TEMP_O[15:8]);
  assign best_next = (scan_addr_d_reg[0] && match_reg) ? scan_data : best_reg;

  // walk all eight pairs; the last match in ascending order wins
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      scan_addr_reg <= 4'h0;
      scan_addr_d_reg <= 4'h0;
      match_reg <= 1'b0;
      best_reg <= 8'h00;
      table_pwm_reg <= 8'h00;
    end else begin
      scan_addr_reg <= scan_addr_reg + 4'h1;
      scan_addr_d_reg <= scan_addr_reg;
      if (!scan_addr_d_reg[0]) begin
        match_reg <= signed'(scan_data) <= temp_int;
      end
      best_reg <= (scan_addr_d_reg == 4'h0) ? 8'h00 : best_next;
      if (scan_addr_d_reg == 4'hf) begin
        table_pwm_reg <= best_next;
      end
    end
  end

  // ****************************************
  // pwm generation
  // ****************************************
  logic [fpt_pkg::DIV_W-1:0] pre_reg, pre_last;
  logic pwm_tick;
  logic [5:0] phase_reg, full_val, duty_sel, phase_inc;

  // clock source, full-duty value and duty source
  assign pre_last = cfg_reg[fpt_pkg::CFG_CLK_SLOW] ? SLOW_LAST : FAST_LAST;
  assign pwm_tick = (pre_reg >= pre_last);
  assign full_val = {freq_reg[fpt_pkg::FREQ_W-1:0], 1'b0};
  assign duty_sel = cfg_reg[fpt_pkg::CFG_DIRECT] ? pwm_value_reg[5:0] : table_pwm_reg[5:0];
  assign phase_inc = phase_reg + 6'h01;

  // prescaler and phase counter over one pwm period
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      pre_reg <= '0;
      phase_reg <= 6'h00;
      PWM_OE_O <= 1'b0;
    end else begin
      pre_reg <= pwm_tick ? '0 : pre_reg + 1'b1;
      if (pwm_tick) begin
        phase_reg <= (phase_inc >= full_val) ? 6'h00 : phase_inc;
      end
      // open drain: pull low for on when polarity low, for off when high
      PWM_OE_O <= ((phase_reg < duty_sel) ^ cfg_reg[fpt_pkg::CFG_POL_HIGH]);
    end
  end

  // ****************************************
  // tachometer period measurement
  // ****************************************
  logic tach_s1_reg, tach_s2_reg, tach_s3_reg, tach_half_reg, tach_en;
  logic [fpt_pkg::DIV_W-1:0] tdiv_reg;
  logic [15:0] tach_run_reg;
  logic tach_tick, tach_rise, tach_done;

  assign tach_en = cfg_reg[fpt_pkg::CFG_TACH_EN0] | cfg_reg[fpt_pkg::CFG_TACH_EN1];
  assign tach_tick = (tdiv_reg >= TACH_LAST);
  assign tach_rise = tach_s2_reg & ~tach_s3_reg;
  assign tach_done = tach_en && tach_rise && tach_half_reg; // two pulses per revolution

  // synchronise pin, count 90 kHz ticks between every second rising edge
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      tach_s1_reg <= 1'b0;
      tach_s2_reg <= 1'b0;
      tach_s3_reg <= 1'b0;
      tach_half_reg <= 1'b0;
      tdiv_reg <= '0;
      tach_run_reg <= 16'h0000;
      tach_count_reg <= 16'h0000;
    end else begin
      tach_s1_reg <= TACH_I;
      tach_s2_reg <= tach_s1_reg;
      tach_s3_reg <= tach_s2_reg;
      tdiv_reg <= tach_tick ? '0 : tdiv_reg + 1'b1;
      if (!tach_en) begin
        tach_half_reg <= 1'b0;
        tach_run_reg <= 16'h0000;
      end else if (tach_done) begin
        tach_half_reg <= 1'b0;
        tach_count_reg <= tach_run_reg;
        tach_run_reg <= {15'h0000, tach_tick}; // tick on the latch edge opens the next period
      end else begin
        if (tach_rise) begin
          tach_half_reg <= 1'b1;
        end
        if (tach_tick && tach_run_reg != fpt_pkg::TACH_MAX) begin
          tach_run_reg <= tach_run_reg + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // offset correction and read path
  // ****************************************
  logic [15:0] temp_sum;
  logic rd_d_reg, snap_tach_hi;
  logic [7:0] addr_d_reg, reg_rd_val;

  assign temp_sum = {REMOTE_TEMP_I[15:5], 5'h00} + {off_hi_reg, off_lo_reg};
  // snapshot taken in the same cycle the low byte is sampled, so both bytes agree
  assign snap_tach_hi = rd_d_reg && (addr_d_reg == fpt_pkg::ADDR_TACH_LOW);

  // register read mux, one cycle after the request
  always_comb begin
    case (addr_d_reg)
      fpt_pkg::ADDR_OFFSET_HIGH: reg_rd_val = off_hi_reg;
      fpt_pkg::ADDR_OFFSET_LOW: reg_rd_val = off_lo_reg;
      fpt_pkg::ADDR_TACH_LOW: reg_rd_val = tach_count_reg[7:0];
      fpt_pkg::ADDR_TACH_HIGH: reg_rd_val = tach_hi_snap_reg;
      fpt_pkg::ADDR_FAN_CONFIG: reg_rd_val = cfg_reg;
      fpt_pkg::ADDR_SPINUP: reg_rd_val = spinup_reg;
      fpt_pkg::ADDR_PWM_VALUE: reg_rd_val = pwm_value_reg;
      fpt_pkg::ADDR_PWM_FREQ: reg_rd_val = freq_reg;
      default: reg_rd_val = is_lut(addr_d_reg) ? host_lut_data : 8'h00;
    endcase
  end

  // corrected temperature, high byte snapshot, read pipeline
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      REMOTE_TEMP_O <= 16'h0000;
      tach_hi_snap_reg <= 8'h00;
      rd_d_reg <= 1'b0;
      addr_d_reg <= 8'h00;
      REG_RDATA_O <= 8'h00;
      REG_RVALID_O <= 1'b0;
    end else begin
      if (REMOTE_TEMP_VALID_I) begin
        REMOTE_TEMP_O <= temp_sum;
      end
      if (snap_tach_hi) begin
        tach_hi_snap_reg <= tach_count_reg[15:8];
      end
      rd_d_reg <= req.rd;
      addr_d_reg <= req.addr;
      REG_RVALID_O <= rd_d_reg;
      if (rd_d_reg) begin
        REG_RDATA_O <= reg_rd_val;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_rd_lo;
    req.rd && req.addr == fpt_pkg::ADDR_TACH_LOW && !tach_done;
  endsequence
  sequence s_rd_hi;
    req.rd && req.addr == fpt_pkg::ADDR_TACH_HIGH;
  endsequence

  pwm_clock_sel_a: assert property (pwm_tick && !$changed(cfg_reg[fpt_pkg::CFG_CLK_SLOW]) |->
    pre_reg == (cfg_reg[fpt_pkg::CFG_CLK_SLOW] ? SLOW_LAST : FAST_LAST))
    else $error("pwm prescaler wrapped at wrong count");
  tach_latch_a: assert property (tach_done |=> tach_count_reg == $past(tach_run_reg) &&
    tach_run_reg == {15'h0000, $past(tach_tick)})
    else $error("tach count not latched on second edge");
  tach_bytes_a: assert property (s_rd_lo ##1 (!req.wr)[*1] ##0 s_rd_hi |-> ##2 REG_RVALID_O && REG_RDATA_O == $past(tach_count_reg[15:8], 3))
    else $error("tach high byte not paired with low byte");
  tach_low_a: assert property (s_rd_lo |-> ##2 REG_RVALID_O && REG_RDATA_O == $past(tach_count_reg[7:0], 2))
    else $error("tach low byte wrong");
  lut_scan_a: assert property (scan_addr_d_reg == 4'hf |=> table_pwm_reg == $past(best_next))
    else $error("table result not committed");
  offset_store_a: assert property (req.wr && req.addr == fpt_pkg::ADDR_OFFSET_HIGH |=> off_hi_reg == $past(req.wdata))
    else $error("offset high not stored");
  temp_corr_a: assert property (REMOTE_TEMP_VALID_I |=> REMOTE_TEMP_O == $past(temp_sum))
    else $error("temperature not corrected");
  duty_out_a: assert property (##1 PWM_OE_O == ($past(phase_reg < duty_sel) ^ $past(cfg_reg[fpt_pkg::CFG_POL_HIGH])))
    else $error("pwm output disagrees with duty");
  table_sel_a: assert property (!cfg_reg[fpt_pkg::CFG_DIRECT] |=>
    PWM_OE_O == ($past(phase_reg < table_pwm_reg[5:0]) ^ $past(cfg_reg[fpt_pkg::CFG_POL_HIGH])))
    else $error("table mode not using table pwm");
  direct_sel_a: assert property (cfg_reg[fpt_pkg::CFG_DIRECT] |=>
    PWM_OE_O == ($past(phase_reg < pwm_value_reg[5:0]) ^ $past(cfg_reg[fpt_pkg::CFG_POL_HIGH])))
    else $error("direct mode not using pwm value");
endmodule : fpt_fan_ctrl

// ==== design/fpt_lut_mem.sv ====
// lookup table storage: one write port, two registered read ports
`timescale 1ns/1ps
module fpt_lut_mem #(
  parameter int WORDS = 16,
  parameter int WIDTH = 8,
  parameter int AW = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_a_i,
  output logic [WIDTH-1:0] rdata_a_o,
  input wire logic [AW-1:0] raddr_b_i,
  output logic [WIDTH-1:0] rdata_b_o
);
  logic [WIDTH-1:0] mem [WORDS];

  if (WORDS > (1 << AW)) begin : g_bad_depth
    $error("fpt_lut_mem: address too narrow");
  end

  // storage write, cleared on reset so the scanner never reads unknowns
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= '0;
      end
    end else if (wr_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // registered reads for host and scanner
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_a_o <= '0;
      rdata_b_o <= '0;
    end else begin
      rdata_a_o <= mem[raddr_a_i];
      rdata_b_o <= mem[raddr_b_i];
    end
  end
endmodule : fpt_lut_mem

// ==== design/fpt_pkg.sv ====
// constants, register map and carrier types of the fan pwm and tach block
// Behaviour
// - pwm timing comes from a slow 1.4 kHz or fast 360 kHz internal clock.
// - fan period counted in 90 kHz ticks over one revolution of two pulses.
// - tach count is 16 bits, low byte at lower address, high byte next.
// - eight temperature and pwm pairs form a non-linear transfer table.
// - two remote temperature offset registers hold a software correction.
// - signed offset is added to each remote temperature result before reporting.
// - duty equals pwm value divided by full-duty value of the frequency setting.
package fpt_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ = 125_000_000;
  localparam int PWM_SLOW_HZ = 1_400;
  localparam int PWM_FAST_HZ = 360_000;
  localparam int TACH_HZ = 90_000;
  localparam int PWM_SLOW_DIV = CLK_HZ / PWM_SLOW_HZ;
  localparam int PWM_FAST_DIV = CLK_HZ / PWM_FAST_HZ;
  localparam int TACH_DIV = CLK_HZ / TACH_HZ;
  localparam int DIV_W = 17;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_OFFSET_HIGH = 8'h11;
  localparam logic [7:0] ADDR_OFFSET_LOW = 8'h12;
  localparam logic [7:0] ADDR_TACH_LOW = 8'h46;
  localparam logic [7:0] ADDR_TACH_HIGH = 8'h47;
  localparam logic [7:0] ADDR_FAN_CONFIG = 8'h4a;
  localparam logic [7:0] ADDR_SPINUP = 8'h4b;
  localparam logic [7:0] ADDR_PWM_VALUE = 8'h4c;
  localparam logic [7:0] ADDR_PWM_FREQ = 8'h4d;
  localparam logic [7:0] ADDR_LUT_BASE = 8'h50;
  localparam logic [7:0] ADDR_LUT_LAST = 8'h5f;
  localparam int LUT_ENTRIES = 8;
  localparam int LUT_WORDS = 16;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CFG_TACH_EN0 = 0;
  localparam int CFG_TACH_EN1 = 1;
  localparam int CFG_CLK_SLOW = 3;
  localparam int CFG_POL_HIGH = 4;
  localparam int CFG_DIRECT = 5;
  localparam logic [7:0] CFG_RST = 8'h20;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int PWM_VAL_W = 6;
  localparam int FREQ_W = 5;
  localparam int SPINUP_W = 6;
  localparam int OFF_FRAC_LSB = 5;
  localparam logic [15:0] TACH_MAX = 16'hffff;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpt_req_s;
endpackage : fpt_pkg
